// File: core/station_io_pkg.sv
// constants, register map and field types for the station io control block
package station_io_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ              = 125_000_000;
  localparam int unsigned SYNTH_BAUD          = 2400;
  localparam int unsigned HALF_BIT_CYCLES     = CLK_HZ / (2 * SYNTH_BAUD);
  localparam int unsigned TXCLK_TIMEOUT_US    = 1000;
  localparam int unsigned TXCLK_TIMEOUT_CYCLES = TXCLK_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FSYNC_PULSE_NS      = 1000;
  localparam int unsigned FSYNC_PULSE_CYCLES  = (FSYNC_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // synthesizer word length
  localparam int unsigned SYNTH_BITS = 24;

  // register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_SYNTH  = 4'h8;
  localparam logic [3:0] ADDR_POWER  = 4'hc;

  // control register: bits 11:0 form ctrl_t, bit 12 is the channel role
  localparam int unsigned CTRL_WIDTH   = 12;
  localparam int unsigned CTRL_ROLE_BIT = 12;

  typedef struct packed {
    logic [1:0] slowCode;      // bits 11:10
    logic       combinedKey;   // bit 9
    logic       voterSquelch;  // bit 8
    logic       guardToneOff;  // bit 7
    logic       acqHigh;       // bit 6
    logic       fastMode;      // bit 5
    logic       remoteKey;     // bit 4
    logic       localKey;      // bit 3
    logic       conventional;  // bit 2
    logic       simulcast;     // bit 1
    logic       legacySwitch;  // bit 0
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // status register bit positions
  localparam int unsigned ST_CARRIER     = 0;
  localparam int unsigned ST_LOCKED      = 1;
  localparam int unsigned ST_LOCK_LOST   = 2;
  localparam int unsigned ST_AMP_FAIL    = 3;
  localparam int unsigned ST_FAR_AUDIO   = 4;
  localparam int unsigned ST_WORKING     = 5;
  localparam int unsigned ST_LOAD_BUSY   = 6;
  localparam int unsigned ST_LOAD_OK     = 7;
  localparam int unsigned ST_SIM_BYPASS  = 8;
  localparam int unsigned ST_SIM_ALARM   = 9;
  localparam int unsigned ST_TXCLK_ALARM = 10;
  localparam int unsigned ST_GUARD_MON   = 11;
  localparam int unsigned ST_VOTER_RCV   = 12;
  localparam int unsigned ST_FSYNC_SEEN  = 13;
  localparam int unsigned ST_WIDTH       = 14;

  // synthesizer loader states
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b00,
    LD_HIGH  = 2'b01,
    LD_LOW   = 2'b10,
    LD_CHECK = 2'b11
  } load_state_t;

endpackage

// File: core/station_io_control.sv
// discrete station control, synthesizer loader and register port
//
// Functional notes
// - mode changes only on failure, command, carrier
// - carrier input is active high
// - local key low keys with local audio
// - remote key low keys with remote audio
// - modulation select high means fast data
// - acquisition output picks limiter time constant
// - mute low on fast tx, no carrier, data
// - slow data from two-bit code outputs
// - loader shifts data, station samples falling clock
// - load enable high only during a load
// - lock checks load and reports lock loss
// - amplifier failure input high means failure
// - far audio input low means present
// - frame sync driven as control, input otherwise
// - eight-bit power monitor value readable
// - override inputs used only in simulcast
// - bypass low forces non-simulcast key and data paths, not the clock alarm
// - inhibit low reports simulcast alarm
// - clock alarm high while simulcast clock missing
// - combined key low keys in conventional mode
// - guard tone disable low blocks guard tone
// - voter squelch low, voter receiving low
`timescale 1ns/100ps
module station_io_control #(
  parameter int unsigned HALF_BIT_CYCLES      = station_io_pkg::HALF_BIT_CYCLES,
  parameter int unsigned TXCLK_TIMEOUT_CYCLES = station_io_pkg::TXCLK_TIMEOUT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [3:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic [31:0]     regRdata,
  input  wire logic       rx_unsquelch,
  input  wire logic       slowDataValid,
  input  wire logic       ctrlChanFail,
  input  wire logic       fastDataIn,
  input  wire logic       fastClkIn,
  input  wire logic       frameSyncReq,
  input  wire logic       synthLocked,
  input  wire logic       amp_failure,
  input  wire logic       far_audio_present_n,
  input  wire logic [7:0] power_monitor_in,
  input  wire logic       override_key_n,
  input  wire logic       override_mod_n,
  input  wire logic       override_slow_n,
  input  wire logic       override_fast_data_n,
  input  wire logic       override_clk_n,
  input  wire logic       simBypass_n,
  input  wire logic       simInhibit_n,
  input  wire logic       guard_monitor_n,
  input  wire logic       voterReceiving_n,
  input  wire logic       frameSyncIn,
  output logic            frameSyncOut,
  output logic            frameSyncOe,
  output logic            local_key_n,
  output logic            remote_key_n,
  output logic            combined_key_n,
  output logic            modSelect,
  output logic            acq_time_const,
  output logic            rx_audio_mute_n,
  output logic            slow_code_bit1,
  output logic            slow_code_bit2,
  output logic            fast_data,
  output logic            fastClk,
  output logic            synthClk,
  output logic            synthData,
  output logic            freq_load_enable,
  output logic            txClkAlarm,
  output logic            guard_tone_disable_n,
  output logic            voterSquelch_n,
  output logic            frameSyncSeen
);

  station_io_pkg::ctrl_t       ctrl_reg;
  logic                        working_reg;
  logic [31:0]                 rdata_reg;
  logic [station_io_pkg::SYNTH_BITS-1:0] shift_reg;
  logic [4:0]                  bitCnt_reg;
  logic [31:0]                 halfCnt_reg;
  station_io_pkg::load_state_t ldState_reg;
  logic                        loadOk_reg;
  logic                        lockLost_reg;
  logic [7:0]                  power_reg;
  logic [31:0]                 clkIdle_reg;
  logic                        clkPrev_reg;
  logic                        carrierPrev_reg;
  logic [7:0]                  fsyncCnt_reg;
  logic                        fsyncPrev_reg;

  logic simActive;
  logic localKeyEff;
  logic fastEff;
  logic halfTick;
  logic wrCtrl;
  logic wrStatus;
  logic wrSynth;
  logic [station_io_pkg::ST_WIDTH-1:0] status;

  assign wrCtrl   = regWrite && (regAddr == station_io_pkg::ADDR_CTRL);
  assign wrStatus = regWrite && (regAddr == station_io_pkg::ADDR_STATUS);
  assign wrSynth  = regWrite && (regAddr == station_io_pkg::ADDR_SYNTH);

  // simulcast overrides only while configured and not bypassed
  assign simActive   = ctrl_reg.simulcast && simBypass_n;
  assign localKeyEff = simActive ? !override_key_n : ctrl_reg.localKey;
  assign fastEff     = simActive ? !override_mod_n : ctrl_reg.fastMode;

  // control register fields; the channel role bit is kept in the next block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= station_io_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_reg <= station_io_pkg::ctrl_t'(regWdata[station_io_pkg::CTRL_WIDTH-1:0]);
    end
  end

  // role moves only on a command, a control channel failure or legacy carrier switching
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      working_reg     <= 1'b0;
      carrierPrev_reg <= 1'b0;
    end else begin
      carrierPrev_reg <= rx_unsquelch;
      if (wrCtrl) begin
        working_reg <= regWdata[station_io_pkg::CTRL_ROLE_BIT];
      end else if (ctrlChanFail) begin
        working_reg <= 1'b0;
      end else if (!working_reg && ctrl_reg.legacySwitch && rx_unsquelch && !carrierPrev_reg) begin
        working_reg <= 1'b1;
      end
    end
  end

  // station keying and path outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      local_key_n          <= 1'b1;
      remote_key_n         <= 1'b1;
      combined_key_n       <= 1'b1;
      modSelect            <= 1'b0;
      acq_time_const       <= 1'b0;
      rx_audio_mute_n      <= 1'b0;
      slow_code_bit1       <= 1'b0;
      slow_code_bit2       <= 1'b0;
      fast_data            <= 1'b0;
      fastClk              <= 1'b0;
      guard_tone_disable_n <= 1'b1;
      voterSquelch_n       <= 1'b1;
    end else begin
      local_key_n    <= !localKeyEff;
      remote_key_n   <= !ctrl_reg.remoteKey;
      combined_key_n <= !(ctrl_reg.conventional && ctrl_reg.combinedKey);
      modSelect      <= fastEff;
      acq_time_const <= ctrl_reg.acqHigh;
      rx_audio_mute_n <= !((fastEff && (localKeyEff || ctrl_reg.remoteKey))
                           || !rx_unsquelch || !slowDataValid);
      slow_code_bit1 <= simActive ? !override_slow_n : ctrl_reg.slowCode[0];
      slow_code_bit2 <= simActive ? !override_slow_n : ctrl_reg.slowCode[1];
      fast_data      <= simActive ? !override_fast_data_n : fastDataIn;
      fastClk        <= simActive ? !override_clk_n : fastClkIn;
      guard_tone_disable_n <= !ctrl_reg.guardToneOff;
      voterSquelch_n <= !ctrl_reg.voterSquelch;
    end
  end

  // half-bit divider for the synthesizer loader, runs only during a load
  assign halfTick = (halfCnt_reg == HALF_BIT_CYCLES - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt_reg <= '0;
    end else if (ldState_reg == station_io_pkg::LD_IDLE || halfTick) begin
      halfCnt_reg <= '0;
    end else begin
      halfCnt_reg <= halfCnt_reg + 32'h1;
    end
  end

  // loader: data set with clock rising, station samples on the falling edge mid-bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ldState_reg      <= station_io_pkg::LD_IDLE;
      shift_reg        <= '0;
      bitCnt_reg       <= '0;
      synthClk         <= 1'b0;
      synthData        <= 1'b0;
      freq_load_enable <= 1'b0;
      loadOk_reg       <= 1'b0;
    end else begin
      case (ldState_reg)
        station_io_pkg::LD_IDLE: begin
          if (wrSynth) begin
            shift_reg        <= {regWdata[station_io_pkg::SYNTH_BITS-2:0], 1'b0};
            synthData        <= regWdata[station_io_pkg::SYNTH_BITS-1];
            synthClk         <= 1'b1;
            freq_load_enable <= 1'b1;
            bitCnt_reg       <= 5'(station_io_pkg::SYNTH_BITS - 1);
            loadOk_reg       <= 1'b0;
            ldState_reg      <= station_io_pkg::LD_HIGH;
          end
        end
        station_io_pkg::LD_HIGH: begin
          if (halfTick) begin
            synthClk    <= 1'b0;
            ldState_reg <= station_io_pkg::LD_LOW;
          end
        end
        station_io_pkg::LD_LOW: begin
          if (halfTick) begin
            if (bitCnt_reg == 5'h0) begin
              ldState_reg <= station_io_pkg::LD_CHECK;
            end else begin
              synthData   <= shift_reg[station_io_pkg::SYNTH_BITS-1];
              shift_reg   <= shift_reg << 1;
              synthClk    <= 1'b1;
              bitCnt_reg  <= bitCnt_reg - 5'h1;
              ldState_reg <= station_io_pkg::LD_HIGH;
            end
          end
        end
        station_io_pkg::LD_CHECK: begin
          if (halfTick) begin
            loadOk_reg       <= synthLocked;
            freq_load_enable <= 1'b0;
            synthData        <= 1'b0;
            ldState_reg      <= station_io_pkg::LD_IDLE;
          end
        end
        default: begin
          ldState_reg      <= station_io_pkg::LD_IDLE;
          freq_load_enable <= 1'b0;
        end
      endcase
    end
  end

  // lock loss is sticky; set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lockLost_reg <= 1'b0;
    end else if (!synthLocked && ldState_reg == station_io_pkg::LD_IDLE) begin
      lockLost_reg <= 1'b1;
    end else if (wrStatus && regWdata[station_io_pkg::ST_LOCK_LOST]) begin
      lockLost_reg <= 1'b0;
    end
  end

  // missing simulcast transmit clock watchdog
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_reg <= 1'b1;
      clkIdle_reg <= '0;
      txClkAlarm  <= 1'b0;
    end else begin
      clkPrev_reg <= override_clk_n;
      if (!ctrl_reg.simulcast || override_clk_n != clkPrev_reg) begin
        clkIdle_reg <= '0;
      end else if (clkIdle_reg < TXCLK_TIMEOUT_CYCLES) begin
        clkIdle_reg <= clkIdle_reg + 32'h1;
      end
      txClkAlarm <= ctrl_reg.simulcast && (clkIdle_reg >= TXCLK_TIMEOUT_CYCLES);
    end
  end

  // frame sync: low pulse driven in control role, watched in working role
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fsyncCnt_reg  <= '0;
      frameSyncOe   <= 1'b0;
      frameSyncOut  <= 1'b0;
      fsyncPrev_reg <= 1'b1;
      frameSyncSeen <= 1'b0;
    end else begin
      frameSyncOut  <= 1'b0;
      fsyncPrev_reg <= frameSyncIn;
      if (working_reg) begin
        fsyncCnt_reg <= '0;
      end else if (frameSyncReq && fsyncCnt_reg == 8'h0) begin
        fsyncCnt_reg <= 8'(station_io_pkg::FSYNC_PULSE_CYCLES);
      end else if (fsyncCnt_reg != 8'h0) begin
        fsyncCnt_reg <= fsyncCnt_reg - 8'h1;
      end
      frameSyncOe   <= !working_reg && (fsyncCnt_reg != 8'h0);
      frameSyncSeen <= working_reg && fsyncPrev_reg && !frameSyncIn;
    end
  end

  // power monitor sample
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= '0;
    end else begin
      power_reg <= power_monitor_in;
    end
  end

  always_comb begin
    status = '0;
    status[station_io_pkg::ST_CARRIER]     = rx_unsquelch;
    status[station_io_pkg::ST_LOCKED]      = synthLocked;
    status[station_io_pkg::ST_LOCK_LOST]   = lockLost_reg;
    status[station_io_pkg::ST_AMP_FAIL]    = amp_failure;
    status[station_io_pkg::ST_FAR_AUDIO]   = !far_audio_present_n;
    status[station_io_pkg::ST_WORKING]     = working_reg;
    status[station_io_pkg::ST_LOAD_BUSY]   = freq_load_enable;
    status[station_io_pkg::ST_LOAD_OK]     = loadOk_reg;
    status[station_io_pkg::ST_SIM_BYPASS]  = !simBypass_n;
    status[station_io_pkg::ST_SIM_ALARM]   = !simInhibit_n;
    status[station_io_pkg::ST_TXCLK_ALARM] = txClkAlarm;
    status[station_io_pkg::ST_GUARD_MON]   = !guard_monitor_n;
    status[station_io_pkg::ST_VOTER_RCV]   = !voterReceiving_n;
    status[station_io_pkg::ST_FSYNC_SEEN]  = frameSyncSeen;
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (regRead) begin
      case (regAddr)
        station_io_pkg::ADDR_CTRL:   rdata_reg <= {19'h0, working_reg, ctrl_reg};
        station_io_pkg::ADDR_STATUS: rdata_reg <= {18'h0, status};
        station_io_pkg::ADDR_SYNTH:  rdata_reg <= {8'h0, shift_reg};
        station_io_pkg::ADDR_POWER:  rdata_reg <= {24'h0, power_reg};
        default:                     rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end
  assign regRdata = rdata_reg;

  // checks
  property p_mute_no_carrier;
    @(posedge clk_sys) disable iff (!rst_n) !rx_unsquelch |=> !rx_audio_mute_n;
  endproperty
  a_mute_no_carrier: assert property (p_mute_no_carrier) else $error("mute not asserted without carrier");

  property p_local_key;
    @(posedge clk_sys) disable iff (!rst_n) (!simActive && ctrl_reg.localKey) |=> !local_key_n;
  endproperty
  a_local_key: assert property (p_local_key) else $error("local key not driven low");

  property p_override_only_sim;
    @(posedge clk_sys) disable iff (!rst_n) !ctrl_reg.simulcast |=> (local_key_n == !$past(ctrl_reg.localKey));
  endproperty
  a_override_only_sim: assert property (p_override_only_sim) else $error("override used outside simulcast");

  property p_bypass;
    @(posedge clk_sys) disable iff (!rst_n) (!simBypass_n && !ctrl_reg.fastMode) |=> !modSelect;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not cancel override");

  property p_load_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (wrSynth && ldState_reg == station_io_pkg::LD_IDLE) |=> freq_load_enable && synthClk;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start");

  property p_clock_only_in_load;
    @(posedge clk_sys) disable iff (!rst_n) $changed(synthClk) |-> freq_load_enable || $past(freq_load_enable);
  endproperty
  a_clock_only_in_load: assert property (p_clock_only_in_load) else $error("clock moved outside load");

  property p_fsync_working;
    @(posedge clk_sys) disable iff (!rst_n) working_reg |=> !frameSyncOe;
  endproperty
  a_fsync_working: assert property (p_fsync_working) else $error("frame sync driven in working role");

  property p_fsync_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      (frameSyncReq && !working_reg && fsyncCnt_reg == 8'h0 && !wrCtrl && !ctrl_reg.legacySwitch) |=> ##1 frameSyncOe;
  endproperty
  a_fsync_pulse: assert property (p_fsync_pulse) else $error("frame sync pulse missing");

  property p_lock_lost;
    @(posedge clk_sys) disable iff (!rst_n)
      (!synthLocked && ldState_reg == station_io_pkg::LD_IDLE) |=> lockLost_reg;
  endproperty
  a_lock_lost: assert property (p_lock_lost) else $error("lock loss not reported");

  property p_clk_alarm_off;
    @(posedge clk_sys) disable iff (!rst_n) !ctrl_reg.simulcast |=> !txClkAlarm;
  endproperty
  a_clk_alarm_off: assert property (p_clk_alarm_off) else $error("clock alarm outside simulcast");

  property p_combined_key;
    @(posedge clk_sys) disable iff (!rst_n) !ctrl_reg.conventional |=> combined_key_n;
  endproperty
  a_combined_key: assert property (p_combined_key) else $error("combined key outside conventional");

endmodule // station_io_control

// File: verif/station_radio_model.sv
// behavioural base station: synthesizer shift capture, lock indication and frame sync line
`timescale 1ns/100ps
module station_radio_model (
  input  wire logic        clk_sys,
  input  wire logic        synthClk,
  input  wire logic        synthData,
  input  wire logic        freq_load_enable,
  input  wire logic        frameSyncOe,
  input  wire logic        frameSyncOut,
  input  wire logic        extSyncLow,
  input  wire logic        breakLock,
  output logic             synthLocked,
  output logic             frameSyncLine,
  output logic [23:0]      loadWord,
  output logic [7:0]       bitCount,
  output logic [7:0]       strayEdges
);
  logic clkPrev;
  logic enPrev;

  initial begin
    clkPrev    = 1'b0;
    enPrev     = 1'b0;
    loadWord   = 24'h000000;
    bitCount   = 8'h00;
    strayEdges = 8'h00;
  end

  // station samples data on the falling loader clock, only while enabled
  always @(posedge clk_sys) begin
    clkPrev <= synthClk;
    enPrev  <= freq_load_enable;
    if (freq_load_enable && !enPrev) begin
      bitCount <= 8'h00;
    end else if (clkPrev && !synthClk) begin
      if (freq_load_enable) begin
        loadWord <= {loadWord[22:0], synthData};
        bitCount <= bitCount + 8'h01;
      end else begin
        strayEdges <= strayEdges + 8'h01;
      end
    end
  end

  // lock reported once a full word has arrived; the bench may pull it away
  assign synthLocked = !breakLock && (bitCount == 8'h18);

  // open-drain line with pull-up: low when anyone sinks it
  assign frameSyncLine = ((frameSyncOe && !frameSyncOut) || extSyncLow) ? 1'b0 : 1'b1;
endmodule // station_radio_model

// File: verif/test_station_io_control.sv
// self-checking bench for the station io control block
`timescale 1ns/100ps
module test_station_io_control;
  logic        clk_sys, rst_n, regWrite, regRead, rx_unsquelch, slowDataValid, ctrlChanFail;
  logic        fastDataIn, fastClkIn, frameSyncReq, amp_failure, far_audio_present_n, override_key_n;
  logic        override_mod_n, override_slow_n, override_fast_data_n, override_clk_n, simBypass_n;
  logic        simInhibit_n, guard_monitor_n, voterReceiving_n, extSyncLow, breakLock;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, rdata;
  logic [7:0]  power_monitor_in;
  wire  [31:0] regRdata;
  wire         frameSyncOut, frameSyncOe, local_key_n, remote_key_n, combined_key_n, modSelect;
  wire         acq_time_const, rx_audio_mute_n, slow_code_bit1, slow_code_bit2, fast_data, fastClk;
  wire         synthClk, synthData, freq_load_enable, txClkAlarm, guard_tone_disable_n;
  wire         voterSquelch_n, frameSyncSeen, synthLocked, frameSyncLine;
  wire  [23:0] loadWord;
  wire  [7:0]  bitCount, strayEdges;
  int          err_total, compares, seen;
  int          sb[6] = '{0, 3, 4, 9, 11, 12};

  station_io_control #(.HALF_BIT_CYCLES(4), .TXCLK_TIMEOUT_CYCLES(20)) station_io_control_inst (
    .clk_sys, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .rx_unsquelch,
    .slowDataValid, .ctrlChanFail, .fastDataIn, .fastClkIn, .frameSyncReq, .synthLocked,
    .amp_failure, .far_audio_present_n, .power_monitor_in, .override_key_n, .override_mod_n,
    .override_slow_n, .override_fast_data_n, .override_clk_n, .simBypass_n, .simInhibit_n,
    .guard_monitor_n, .voterReceiving_n, .frameSyncIn(frameSyncLine), .frameSyncOut, .frameSyncOe,
    .local_key_n, .remote_key_n, .combined_key_n, .modSelect, .acq_time_const, .rx_audio_mute_n,
    .slow_code_bit1, .slow_code_bit2, .fast_data, .fastClk, .synthClk, .synthData,
    .freq_load_enable, .txClkAlarm, .guard_tone_disable_n, .voterSquelch_n, .frameSyncSeen);

  station_radio_model station_radio_model_inst (
    .clk_sys, .synthClk, .synthData, .freq_load_enable, .frameSyncOe, .frameSyncOut, .extSyncLow,
    .breakLock, .synthLocked, .frameSyncLine, .loadWord, .bitCount, .strayEdges);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    // data stands for one cycle; take it at the edge that closes it
    @(posedge clk_sys);
    rdata = regRdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pin(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  task automatic st(input int b, input logic e);
    rd(station_io_pkg::ADDR_STATUS);
    chk({31'h0, rdata[b]}, {31'h0, e});
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  initial begin
    {rst_n, regWrite, regRead, rx_unsquelch, slowDataValid, ctrlChanFail, fastDataIn} = 7'h00;
    {fastClkIn, frameSyncReq, amp_failure, extSyncLow, breakLock} = 5'h00;
    {far_audio_present_n, override_key_n, override_mod_n, override_slow_n} = 4'hf;
    {override_fast_data_n, override_clk_n, simBypass_n, simInhibit_n} = 4'hf;
    {guard_monitor_n, voterReceiving_n} = 2'h3;
    regAddr = 4'h0;
    regWdata = 32'h0;
    power_monitor_in = 8'h5a;
    tick(10);
    pin(local_key_n, 1'b1);
    pin(remote_key_n, 1'b1);
    pin(combined_key_n, 1'b1);
    pin(freq_load_enable, 1'b0);
    pin(rx_audio_mute_n, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(3);
    pin(rx_audio_mute_n, 1'b0);
    rd(station_io_pkg::ADDR_POWER);
    chk(rdata, 32'h0000005a);
    @(posedge clk_sys);
    chk(regRdata, 32'h00000000);
    rd(4'h2);
    chk(rdata, 32'h00000000);
    // carrier, amplifier, far audio, inhibit, guard and voter inputs driven active, then all but carrier released
    rx_unsquelch <= 1'b1;
    {amp_failure, far_audio_present_n, simInhibit_n, guard_monitor_n, voterReceiving_n} <= 5'h10;
    tick(3);
    foreach (sb[i]) st(sb[i], 1'b1);
    {amp_failure, far_audio_present_n, simInhibit_n, guard_monitor_n, voterReceiving_n} <= 5'h0f;
    tick(3);
    for (int i = 1; i < 6; i++) st(sb[i], 1'b0);
    slowDataValid <= 1'b1;
    tick(3);
    pin(rx_audio_mute_n, 1'b1);
    // conventional, local key, fast path, high time constant, guard off, voter squelch, code 11
    wr(station_io_pkg::ADDR_CTRL, 32'h00000fec);
    tick(3);
    pin(local_key_n, 1'b0);
    pin(modSelect, 1'b1);
    pin(acq_time_const, 1'b1);
    pin(slow_code_bit1 & slow_code_bit2, 1'b1);
    pin(combined_key_n, 1'b0);
    pin(guard_tone_disable_n, 1'b0);
    pin(voterSquelch_n, 1'b0);
    pin(rx_audio_mute_n, 1'b0);
    wr(station_io_pkg::ADDR_CTRL, 32'h00000010);
    tick(3);
    pin(remote_key_n, 1'b0);
    pin(local_key_n, 1'b1);
    pin(modSelect, 1'b0);
    pin(acq_time_const, 1'b0);
    pin(slow_code_bit1 | slow_code_bit2, 1'b0);
    pin(rx_audio_mute_n, 1'b1);
    rx_unsquelch <= 1'b0;
    tick(3);
    pin(rx_audio_mute_n, 1'b0);
    rx_unsquelch <= 1'b1;
    slowDataValid <= 1'b0;
    tick(3);
    pin(rx_audio_mute_n, 1'b0);
    slowDataValid <= 1'b1;
    wr(station_io_pkg::ADDR_CTRL, 32'h00000000);
    // synthesizer load; a second word sent mid-load must be ignored
    wr(station_io_pkg::ADDR_SYNTH, 32'h00a5c396);
    tick(2);
    pin(freq_load_enable, 1'b1);
    st(6, 1'b1);
    wr(station_io_pkg::ADDR_SYNTH, 32'h00123456);
    for (int i = 0; i < 600 && freq_load_enable; i++) @(posedge clk_sys);
    tick(2);
    pin(freq_load_enable, 1'b0);
    chk({8'h0, loadWord}, 32'h00a5c396);
    chk({24'h0, bitCount}, 32'h00000018);
    chk({24'h0, strayEdges}, 32'h00000000);
    st(7, 1'b1);
    wr(station_io_pkg::ADDR_STATUS, 32'h00000004);
    st(2, 1'b0);
    breakLock <= 1'b1;
    tick(3);
    st(2, 1'b1);
    st(1, 1'b0);
    breakLock <= 1'b0;
    // control role drives the frame sync line, working role only listens
    frameSyncReq <= 1'b1;
    tick(1);
    frameSyncReq <= 1'b0;
    tick(3);
    pin(frameSyncOe, 1'b1);
    pin(frameSyncLine, 1'b0);
    tick(130);
    pin(frameSyncOe, 1'b0);
    wr(station_io_pkg::ADDR_CTRL, 32'h00001000);
    st(5, 1'b1);
    rd(station_io_pkg::ADDR_CTRL);
    chk(rdata, 32'h00001000);
    frameSyncReq <= 1'b1;
    tick(1);
    frameSyncReq <= 1'b0;
    extSyncLow <= 1'b1;
    seen = 0;
    repeat (8) begin
      tick(1);
      seen += int'(frameSyncSeen === 1'b1);
      pin(frameSyncOe, 1'b0);
    end
    chk(32'(seen), 32'h00000001);
    extSyncLow <= 1'b0;
    ctrlChanFail <= 1'b1;
    tick(1);
    ctrlChanFail <= 1'b0;
    st(5, 1'b0);
    // carrier rise switches role only with the legacy behaviour enabled
    foreach (sb[i]) begin
      if (i < 2) begin
        rx_unsquelch <= 1'b0;
        wr(station_io_pkg::ADDR_CTRL, (i == 0) ? 32'h00000001 : 32'h00000000);
        tick(2);
        rx_unsquelch <= 1'b1;
        tick(3);
        st(5, (i == 0));
      end
    end
    // simulcast overrides, bypass and clock alarm
    wr(station_io_pkg::ADDR_CTRL, 32'h00000002);
    override_key_n <= 1'b0;
    override_fast_data_n <= 1'b0;
    {override_mod_n, override_slow_n} <= 2'h0;
    fastClkIn <= 1'b1;
    tick(3);
    pin(local_key_n, 1'b0);
    pin(fast_data, 1'b1);
    pin(modSelect, 1'b1);
    pin(slow_code_bit1 & slow_code_bit2, 1'b1);
    pin(fastClk, 1'b0);
    tick(25);
    pin(txClkAlarm, 1'b1);
    simBypass_n <= 1'b0;
    tick(3);
    pin(local_key_n, 1'b1);
    pin(modSelect, 1'b0);
    st(8, 1'b1);
    simBypass_n <= 1'b1;
    wr(station_io_pkg::ADDR_CTRL, 32'h00000000);
    tick(30);
    pin(local_key_n, 1'b1);
    pin(fast_data, 1'b0);
    pin(modSelect, 1'b0);
    pin(fastClk, 1'b1);
    pin(txClkAlarm, 1'b0);
    wrap_up();
  end
endmodule // test_station_io_control
